/* File: src/pll_clock_generator_control.sv */
// Operation
// - base clock is selected source halved
// - select 1 picks vco, 0 crystal
// - switch waits three crystal edges, plus three vco edges if loop runs, output frozen
// - select forced 0 if loop off/range zero
// - loop on held while select is 1
// - programming register locked while loop on
// - loop on bit resets to one
// - irq enable forced 0 in manual mode
// - change flag sets on lock toggle in auto mode
// - reading loop control clears change flag
// - interrupt is flag, enable and auto mode
// - low loop control bits read ones
// - auto bandwidth bit resets to manual
// - lock reads detector in auto, else 0
// - filter bit writable manual, status in auto
// - oscillator enable gates crystal and loop
// - multiplier zero means one, resets six
// - vco range resets to six
// - filter bit saved across auto mode
`timescale 1ns/1ps
`include "clockgen_defines.svh"

module pll_clock_generator_control #(
   parameter int ADDR_W = 18
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output clockgen_pkg::axi_resp_type bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output clockgen_pkg::axi_resp_type rresp,
   output logic rvalid,
   input wire logic rready,
   // source clocks and lock detector pins
   input wire logic crystal_clock,
   input wire logic vco_clock,
   input wire logic lock_detect_in,
   input wire logic track_detect_in,
   // system integration unit side
   input wire logic osc_enable_in,
   output logic base_clock_out,
   output logic clockgen_irq,
   // analog loop controls
   output logic osc_run_out,
   output logic loop_run_out,
   output logic [3:0] feedback_multiplier_out,
   output logic [3:0] vco_range_out,
   output logic filter_track_out,
   output logic auto_bandwidth_out
);
   import clockgen_pkg::*;

   // word index plus two byte bits must fit the address bus
   if (ADDR_W < 18) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end

   // ==========================================================
   // pin synchronizers
   // bit 0 crystal, 1 vco, 2 lock, 3 track
   logic [3:0] pin_raw; // raw pin levels
   logic [3:0] sync1_reg; // first stage, read only by second
   logic [3:0] sync2_reg; // second stage
   logic [3:0] sync3_reg; // third stage
   logic [3:0] pin_reg; // accepted level
   logic [3:0] pin_next; // level after this cycle
   logic [3:0] pin_rise; // accepted rising change

   assign pin_raw = {track_detect_in, lock_detect_in, vco_clock, crystal_clock};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         // a change counts once stages two and three agree
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
               sync3_reg[gi] <= 1'b0;
               pin_reg[gi] <= 1'b0;
            end else if (clk_en) begin
               sync1_reg[gi] <= pin_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi];
               pin_reg[gi] <= pin_next[gi];
            end
         end
         assign pin_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync2_reg[gi] : pin_reg[gi];
         assign pin_rise[gi] = pin_next[gi] & ~pin_reg[gi];
      end
   endgenerate

   // ==========================================================
   // control state
   logic irq_enable_reg; // lock interrupt enable
   logic change_flag_reg; // lock change flag
   logic power_on_reg; // loop power on
   logic select_reg; // base clock select
   logic auto_reg; // automatic bandwidth
   logic filter_manual_reg; // manual filter mode, kept across auto
   logic loss_reg; // crystal loss check pending
   logic [3:0] mult_reg; // feedback multiplier field
   logic [3:0] range_reg; // vco range field

   logic loop_run; // loop and vco really running
   logic crystal_edge; // gated crystal rising edge
   logic vco_edge; // gated vco rising edge
   logic lock_level; // accepted lock indicator
   logic lock_toggle; // any change of lock indicator

   // oscillator enable gates both sources
   assign osc_run_out = osc_enable_in;
   assign loop_run = osc_enable_in & power_on_reg & (range_reg != 4'h0);
   assign loop_run_out = loop_run;
   assign crystal_edge = pin_rise[0] & osc_enable_in;
   assign vco_edge = pin_rise[1] & loop_run;
   assign lock_level = pin_reg[2];
   assign lock_toggle = pin_next[2] ^ pin_reg[2];

   // zero multiplier acts as one
   assign feedback_multiplier_out = (mult_reg == 4'h0) ? 4'h1 : mult_reg;
   assign vco_range_out = range_reg;
   // in auto mode the detector drives the filter, else the manual bit
   assign filter_track_out = auto_reg ? pin_reg[3] : filter_manual_reg;
   assign auto_bandwidth_out = auto_reg;

   // ==========================================================
   // axi4-lite slave
   logic aw_hold_reg; // write address captured
   logic w_hold_reg; // write data captured
   logic [ADDR_W-1:0] waddr_reg; // captured write address
   logic [7:0] wbyte_reg; // captured low data byte
   logic wlane_reg; // low byte lane strobe
   logic bvalid_reg; // write response pending
   axi_resp_type bresp_reg; // write response code
   logic rvalid_reg; // read data pending
   axi_resp_type rresp_reg; // read response code
   logic [31:0] rdata_reg; // read data
   logic do_write; // perform captured write this cycle
   logic do_read; // read address taken this cycle
   logic [ADDR_W-3:0] wword; // write word index
   logic [ADDR_W-3:0] rword; // read word index
   logic wr_lc; // write hits loop control
   logic wr_bw; // write hits bandwidth control
   logic wr_pg; // write hits loop programming
   logic rd_lc; // read hits loop control
   logic rd_hit; // read hits any register
   logic [7:0] rd_byte; // read mux value

   // ready outputs are combinational and held low while disabled, valid and response outputs are registered
   assign awready = clk_en & ~aw_hold_reg & ~bvalid_reg;
   assign wready = clk_en & ~w_hold_reg & ~bvalid_reg;
   assign arready = clk_en & ~rvalid_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rresp = rresp_reg;
   assign rdata = rdata_reg;

   assign do_write = clk_en & aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign do_read = arvalid & arready;
   assign wword = waddr_reg[ADDR_W-1:2];
   assign rword = araddr[ADDR_W-1:2];
   assign wr_lc = do_write & wlane_reg & (wword == (ADDR_W-2)'(`LOOP_CONTROL_IDX));
   assign wr_bw = do_write & wlane_reg & (wword == (ADDR_W-2)'(`BANDWIDTH_CONTROL_IDX));
   assign wr_pg = do_write & wlane_reg & (wword == (ADDR_W-2)'(`LOOP_PROGRAM_IDX));
   assign rd_lc = do_read & (rword == (ADDR_W-2)'(`LOOP_CONTROL_IDX));

   // address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         waddr_reg <= '0;
         wbyte_reg <= 8'h00;
         wlane_reg <= 1'b0;
      end else if (clk_en) begin
         if (awvalid && awready) begin
            aw_hold_reg <= 1'b1;
            waddr_reg <= awaddr;
         end else if (do_write) begin
            aw_hold_reg <= 1'b0;
         end
         if (wvalid && wready) begin
            w_hold_reg <= 1'b1;
            wbyte_reg <= wdata[7:0];
            wlane_reg <= wstrb[0];
         end else if (do_write) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   // write response, unmapped words answer slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
      end else if (clk_en) begin
         if (do_write) begin
            bvalid_reg <= 1'b1;
            if (wword == (ADDR_W-2)'(`LOOP_CONTROL_IDX) || wword == (ADDR_W-2)'(`BANDWIDTH_CONTROL_IDX) ||
                wword == (ADDR_W-2)'(`LOOP_PROGRAM_IDX)) begin
               bresp_reg <= `RESP_OKAY;
            end else begin
               bresp_reg <= `RESP_SLVERR;
            end
         end else if (bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // read mux, upper data bits read zero
   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      if (rword == (ADDR_W-2)'(`LOOP_CONTROL_IDX)) begin
         rd_byte[`LC_IRQ_ENABLE_BIT] = irq_enable_reg;
         rd_byte[`LC_CHANGE_FLAG_BIT] = change_flag_reg & auto_reg;
         rd_byte[`LC_POWER_ON_BIT] = power_on_reg;
         rd_byte[`LC_BASE_SELECT_BIT] = select_reg;
         rd_byte[3:0] = `LC_UNUSED_ONES;
      end else if (rword == (ADDR_W-2)'(`BANDWIDTH_CONTROL_IDX)) begin
         rd_byte[`BW_AUTO_BIT] = auto_reg;
         rd_byte[`BW_LOCK_BIT] = auto_reg & lock_level;
         rd_byte[`BW_FILTER_MODE_BIT] = auto_reg ? pin_reg[3] : filter_manual_reg;
         rd_byte[`BW_CRYSTAL_LOSS_BIT] = loss_reg & select_reg;
         rd_byte[3:0] = 4'h0;
      end else if (rword == (ADDR_W-2)'(`LOOP_PROGRAM_IDX)) begin
         rd_byte = {mult_reg, range_reg};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // read data is registered one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= `RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         if (do_read) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, rd_byte};
            rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // loop control register
   // the interlocks use the old bits, so selecting the vco from off takes two writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_on_reg <= `RST_POWER_ON;
         select_reg <= 1'b0;
         irq_enable_reg <= 1'b0;
      end else if (clk_en) begin
         if (select_reg) begin
            power_on_reg <= 1'b1;
         end else if (wr_lc) begin
            power_on_reg <= wbyte_reg[`LC_POWER_ON_BIT];
         end
         if (!power_on_reg || range_reg == 4'h0) begin
            select_reg <= 1'b0;
         end else if (wr_lc) begin
            select_reg <= wbyte_reg[`LC_BASE_SELECT_BIT];
         end
         if (!auto_reg) begin
            irq_enable_reg <= 1'b0;
         end else if (wr_lc) begin
            irq_enable_reg <= wbyte_reg[`LC_IRQ_ENABLE_BIT];
         end
      end
   end

   // lock change flag: a toggle in the clearing cycle still sets it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         change_flag_reg <= 1'b0;
      end else if (clk_en) begin
         if (!auto_reg) begin
            change_flag_reg <= 1'b0;
         end else if (lock_toggle) begin
            change_flag_reg <= 1'b1;
         end else if (rd_lc) begin
            change_flag_reg <= 1'b0;
         end
      end
   end

   assign clockgen_irq = change_flag_reg & irq_enable_reg & auto_reg;

   // ==========================================================
   // bandwidth control register
   // software must clear the manual filter bit before powering the loop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         auto_reg <= 1'b0;
         filter_manual_reg <= 1'b0;
         loss_reg <= 1'b0;
      end else if (clk_en) begin
         if (wr_bw) begin
            auto_reg <= wbyte_reg[`BW_AUTO_BIT];
         end
         // manual value is only touched while manual, so auto mode keeps it
         if (wr_bw && !auto_reg) begin
            filter_manual_reg <= wbyte_reg[`BW_FILTER_MODE_BIT];
         end
         // loss check: armed by a one, cleared by any crystal edge
         if (!select_reg) begin
            loss_reg <= 1'b0;
         end else if (crystal_edge) begin
            loss_reg <= 1'b0;
         end else if (wr_bw && wbyte_reg[`BW_CRYSTAL_LOSS_BIT]) begin
            loss_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // loop programming register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mult_reg <= `RST_MULTIPLIER;
         range_reg <= `RST_VCO_RANGE;
      end else if (clk_en) begin
         if (wr_pg && !power_on_reg) begin
            mult_reg <= wbyte_reg[7:4];
            range_reg <= wbyte_reg[3:0];
         end
      end
   end

   // ==========================================================
   // base clock selector
   // sources are sampled on aclk, so each must stay below a quarter of its rate
   sel_state_type sel_state_reg; // selector state
   logic source_reg; // source now driving the output
   logic [1:0] xcount_reg; // crystal edges seen while switching
   logic [1:0] vcount_reg; // vco edges seen while switching
   logic base_reg; // halved clock
   logic source_edge; // rising edge of the active source

   assign source_edge = source_reg ? vco_edge : crystal_edge;
   assign base_clock_out = base_reg;

   // switch state machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_state_reg <= SEL_RUN;
         source_reg <= 1'b0;
         xcount_reg <= 2'h0;
         vcount_reg <= 2'h0;
      end else if (clk_en) begin
         case (sel_state_reg)
            SEL_RUN: begin
               xcount_reg <= 2'h0;
               vcount_reg <= 2'h0;
               if (select_reg != source_reg) begin
                  sel_state_reg <= SEL_SWITCH;
               end
            end
            SEL_SWITCH: begin
               if (crystal_edge && xcount_reg != `SWITCH_EDGES) begin
                  xcount_reg <= xcount_reg + 2'h1;
               end
               if (vco_edge && vcount_reg != `SWITCH_EDGES) begin
                  vcount_reg <= vcount_reg + 2'h1;
               end
               // a select that returns to the old source ends the wait
               if (select_reg == source_reg) begin
                  sel_state_reg <= SEL_RUN;
               end else if (xcount_reg == `SWITCH_EDGES && (vcount_reg == `SWITCH_EDGES || !loop_run)) begin
                  source_reg <= select_reg;
                  sel_state_reg <= SEL_RUN;
               end
            end
            default: begin
               sel_state_reg <= SEL_RUN;
            end
         endcase
      end
   end

   // halving gives an even duty cycle whatever the source duty
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_reg <= 1'b0;
      end else if (clk_en) begin
         if (sel_state_reg == SEL_RUN && source_edge) begin
            base_reg <= ~base_reg;
         end
      end
   end

   // protection bits are accepted and not used
   logic unused_prot;
   assign unused_prot = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};

endmodule

/* File: src/clockgen_defines.svh */
`ifndef CLOCKGEN_DEFINES_SVH
`define CLOCKGEN_DEFINES_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define LOOP_CONTROL_IDX 16'hfe0b
`define BANDWIDTH_CONTROL_IDX 16'hfe0c
`define LOOP_PROGRAM_IDX 16'hfe0d

// ==========================================================
// loop control field positions
`define LC_IRQ_ENABLE_BIT 7
`define LC_CHANGE_FLAG_BIT 6
`define LC_POWER_ON_BIT 5
`define LC_BASE_SELECT_BIT 4
`define LC_UNUSED_ONES 4'hf

// ==========================================================
// bandwidth control field positions
`define BW_AUTO_BIT 7
`define BW_LOCK_BIT 6
`define BW_FILTER_MODE_BIT 5
`define BW_CRYSTAL_LOSS_BIT 4

// ==========================================================
// reset values
`define RST_POWER_ON 1'b1
`define RST_MULTIPLIER 4'h6
`define RST_VCO_RANGE 4'h6

// ==========================================================
// timing counts: source clock edges waited on a base clock switch
`define SWITCH_EDGES 2'h3

// ==========================================================
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: src/clockgen_pkg.sv */
package clockgen_pkg;
   // axi response code
   typedef logic [1:0] axi_resp_type;
   // base clock selector state
   typedef enum logic [0:0] {SEL_RUN, SEL_SWITCH} sel_state_type;
endpackage

/* File: tb/pll_clock_generator_control_properties.sv */
`timescale 1ns/1ps
// ==========================================================
// port-level checker for the clock generator control block
module pll_clock_generator_control_properties #(
   parameter int ADDR_W = 18
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input clockgen_pkg::axi_resp_type bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input clockgen_pkg::axi_resp_type rresp,
   // clock and loop controls
   input wire logic osc_enable_in,
   input wire logic osc_run_out,
   input wire logic loop_run_out,
   input wire logic [3:0] feedback_multiplier_out,
   input wire logic [3:0] vco_range_out,
   input wire logic base_clock_out,
   input wire logic clockgen_irq,
   input wire logic auto_bandwidth_out
);
   import clockgen_pkg::*;
   // one domain, so clock and reset are given once
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // properties
   property p_irq_auto; clockgen_irq |-> auto_bandwidth_out; endproperty
   property p_osc; osc_run_out == osc_enable_in; endproperty
   property p_loop_run; loop_run_out |-> osc_enable_in && vco_range_out != 4'h0; endproperty
   property p_mult; feedback_multiplier_out != 4'h0; endproperty
   // source held two cycles a level, so toggles are never closer than four
   property p_base; $changed(base_clock_out) |=> $stable(base_clock_out) [*3]; endproperty
   property p_range_hold; loop_run_out |=> $stable(vco_range_out); endproperty
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
   property p_wr_lat; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
   property p_rd_lat; arvalid && arready |=> rvalid; endproperty
   // ==========================================================
   // assertions
   a_irq_auto: assert property (p_irq_auto) else $error("irq without auto mode");
   a_osc: assert property (p_osc) else $error("oscillator run differs from enable");
   a_loop_run: assert property (p_loop_run) else $error("loop runs while gated");
   a_mult: assert property (p_mult) else $error("multiplier output zero");
   a_base: assert property (p_base) else $error("base clock toggles too fast");
   a_range_hold: assert property (p_range_hold) else $error("range changed with loop on");
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   a_r_hold: assert property (p_r_hold) else $error("read response dropped");
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   // ==========================================================
   // covers
   c_irq: cover property (clockgen_irq);
   c_slverr: cover property (rvalid && rresp == 2'h2);
   c_base: cover property ($changed(base_clock_out));
endmodule

/* File: tb/sim_clock_partner.sv */
`timescale 1ns/1ps
// ==========================================================
// far side: source clocks plus base clock consumer
module sim_clock_partner (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bench control
   input wire logic osc_request,
   // design side
   input wire logic osc_run_out,
   input wire logic loop_run_out,
   input wire logic base_clock_out,
   output logic osc_enable_in,
   output logic crystal_clock,
   output logic vco_clock,
   output int gap
);
   int xc; // crystal phase, period 8 cycles
   int vc; // vco phase, period 12 cycles
   int run; // cycles since last base toggle
   logic last_base;
   assign osc_enable_in = osc_request;
   assign crystal_clock = xc < 4;
   assign vco_clock = vc < 6;
   // sources stand still while gated, as real oscillators would
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xc <= 0;
         vc <= 0;
      end else begin
         if (osc_run_out) xc <= (xc == 7) ? 0 : xc + 1;
         if (loop_run_out) vc <= (vc == 11) ? 0 : vc + 1;
      end
   end
   // toggle spacing tells which source drives the base clock
   always_ff @(posedge aclk) begin
      last_base <= base_clock_out;
      if (!aresetn) begin
         run <= 0;
         gap <= 0;
      end else if (base_clock_out != last_base) begin
         gap <= run + 1;
         run <= 0;
      end else run <= run + 1;
   end
endmodule

/* File: tb/pll_clock_generator_control_tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// register-level bench
module pll_clock_generator_control_tb_top;
   import clockgen_pkg::*;
   localparam logic [17:0] A_LC = 18'h3f82c;
   localparam logic [17:0] A_BW = 18'h3f830;
   localparam logic [17:0] A_PG = 18'h3f834;
   localparam logic [17:0] A_BAD = 18'h00100;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [17:0] awaddr;
   logic [17:0] araddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   axi_resp_type bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, base_clock_out, clockgen_irq;
   logic osc_run_out, loop_run_out, crystal_clock, vco_clock, osc_enable_in, osc_request;
   logic lock_detect_in, track_detect_in, filter_track_out;
   logic [3:0] feedback_multiplier_out;
   int gap;
   int n_errors, compares;
   // ==========================================================
   // design and far side
   pll_clock_generator_control DUT (.aclk, .aresetn, .clk_en(1'b1), .awaddr, .awprot(3'h0), .awvalid,
      .awready, .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .crystal_clock, .vco_clock,
      .lock_detect_in, .track_detect_in, .osc_enable_in, .base_clock_out, .clockgen_irq, .osc_run_out,
      .loop_run_out, .feedback_multiplier_out, .vco_range_out(), .filter_track_out,
      .auto_bandwidth_out());
   sim_clock_partner partner (.aclk, .aresetn, .osc_request, .osc_run_out, .loop_run_out,
      .base_clock_out, .osc_enable_in, .crystal_clock, .vco_clock, .gap);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ==========================================================
   // checking and closing
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic tmo();
      n_errors++;
      $display("BAD handshake expected answer seen none");
      report_and_stop();
   endtask
   // ==========================================================
   // bus tasks: ready is sampled at the falling edge, where it is settled
   task automatic wr(input logic [17:0] a, input logic [7:0] d, input axi_resp_type er);
      logic ta, tw, tb;
      axi_resp_type r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      for (int i = 0; i < 50 && !tb; i++) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid & bready;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      if (!tb) tmo();
      chk("bresp", {30'h0, r}, {30'h0, er});
   endtask
   task automatic rdc(input string n, input logic [17:0] a, input logic [7:0] e, input axi_resp_type er);
      logic ta, tr;
      logic [31:0] d;
      axi_resp_type r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      for (int i = 0; i < 50 && !tr; i++) begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
      if (!tr) tmo();
      chk(n, d, {24'h0, e});
      chk("rresp", {30'h0, r}, {30'h0, er});
   endtask
   // ==========================================================
   // main sequence
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 18'h0;
      araddr = 18'h0;
      wdata = 32'h0;
      osc_request = 1'b1;
      lock_detect_in = 1'b0;
      track_detect_in = 1'b0;
      n_errors = 0;
      compares = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rdc("lc reset", A_LC, 8'h2f, 2'h0);
      rdc("bw reset", A_BW, 8'h00, 2'h0);
      rdc("pg reset", A_PG, 8'h66, 2'h0);
      rdc("unmapped", A_BAD, 8'h00, 2'h2);
      wr(A_BAD, 8'h55, 2'h2);
      wr(A_PG, 8'h12, 2'h0);
      rdc("pg locked", A_PG, 8'h66, 2'h0);
      wr(A_LC, 8'haf, 2'h0);
      rdc("irq en manual", A_LC, 8'h2f, 2'h0);
      wr(A_LC, 8'h00, 2'h0);
      rdc("loop off", A_LC, 8'h0f, 2'h0);
      wr(A_PG, 8'h00, 2'h0);
      rdc("pg open", A_PG, 8'h00, 2'h0);
      @(negedge aclk);
      chk("mult zero", {28'h0, feedback_multiplier_out}, 32'h1);
      wr(A_LC, 8'h20, 2'h0);
      wr(A_LC, 8'h30, 2'h0);
      rdc("range zero", A_LC, 8'h2f, 2'h0);
      wr(A_LC, 8'h00, 2'h0);
      wr(A_PG, 8'h66, 2'h0);
      wr(A_LC, 8'h30, 2'h0);
      rdc("first write", A_LC, 8'h2f, 2'h0);
      wr(A_LC, 8'h30, 2'h0);
      rdc("vco select", A_LC, 8'h3f, 2'h0);
      repeat (150) @(posedge aclk);
      chk("vco gap", gap, 32'd12);
      wr(A_LC, 8'h00, 2'h0);
      rdc("power held", A_LC, 8'h2f, 2'h0);
      repeat (150) @(posedge aclk);
      chk("crystal gap", gap, 32'd8);
      osc_request <= 1'b0;
      @(negedge aclk);
      chk("osc gate", {30'h0, osc_run_out, loop_run_out}, 32'h0);
      @(posedge aclk);
      osc_request <= 1'b1;
      wr(A_BW, 8'h20, 2'h0);
      rdc("filter manual", A_BW, 8'h20, 2'h0);
      @(negedge aclk);
      chk("track out", {31'h0, filter_track_out}, 32'h1);
      wr(A_BW, 8'ha0, 2'h0);
      rdc("filter auto", A_BW, 8'h80, 2'h0);
      wr(A_BW, 8'h00, 2'h0);
      rdc("filter kept", A_BW, 8'h20, 2'h0);
      wr(A_BW, 8'h80, 2'h0);
      wr(A_LC, 8'ha0, 2'h0);
      rdc("irq en auto", A_LC, 8'haf, 2'h0);
      lock_detect_in <= 1'b1;
      repeat (8) @(posedge aclk);
      @(negedge aclk);
      chk("irq set", {31'h0, clockgen_irq}, 32'h1);
      rdc("lock auto", A_BW, 8'hc0, 2'h0);
      rdc("flag set", A_LC, 8'hef, 2'h0);
      @(negedge aclk);
      chk("irq clear", {31'h0, clockgen_irq}, 32'h0);
      rdc("flag clear", A_LC, 8'haf, 2'h0);
      wr(A_BW, 8'h00, 2'h0);
      lock_detect_in <= 1'b0;
      repeat (8) @(posedge aclk);
      rdc("manual flags", A_LC, 8'h2f, 2'h0);
      report_and_stop();
   end
endmodule
bind pll_clock_generator_control pll_clock_generator_control_properties #(.ADDR_W(ADDR_W)) u_props (
   .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
   .rvalid, .rready, .rdata, .rresp, .osc_enable_in, .osc_run_out, .loop_run_out,
   .feedback_multiplier_out, .vco_range_out, .base_clock_out, .clockgen_irq, .auto_bandwidth_out);
